/* mecr_cfg.svh */
// Purpose: constants of the master error code reporter
// Assumes: included by the package only
// Notes:   offsets are byte addresses on the register bus
`ifndef MECR_CFG_SVH
`define MECR_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define MECR_OFF_STATUS 8'h00
`define MECR_OFF_MASK   8'h04
`define MECR_OFF_CODE   8'h08
`define MECR_OFF_CTRL   8'h0C
`define MECR_OFF_ADDR   8'h10
// ----------------------------------------
// control register bits
// ----------------------------------------
`define MECR_CTRL_ERRACT 0
`define MECR_CTRL_AUTO   1
`define MECR_CTRL_LEAVE  2
`define MECR_CTRL_CCLR   3
`define MECR_CTRL_CLRST  4
`define MECR_CTRL_WIN    5
// ----------------------------------------
// reset values and the standby address limit
// ----------------------------------------
`define MECR_RST_MASK   18'h3FFFF
`define MECR_RST_SBY    7'h01
`define MECR_RST_CTL    7'h02
`define MECR_ADDR_MAX   7'h7D
// ----------------------------------------
// event bit positions
// ----------------------------------------
`define MECR_EV_F110 0
`define MECR_EV_F111 1
`define MECR_EV_F112 2
`define MECR_EV_F113 3
`define MECR_EV_F114 4
`define MECR_EV_F120 5
`define MECR_EV_F125 10
`define MECR_EV_FB00 12
`define MECR_EV_FB01 13
`define MECR_EV_F100 17
// indicator groups over the event bits
`define MECR_FAULT_GRP 18'h3F010
`define MECR_RSP_GRP   18'h00FE0
// ----------------------------------------
// pin positions in the synchronised vector
// ----------------------------------------
`define MECR_PIN_W    14
`define MECR_PIN_REQ  0
`define MECR_PIN_RD   1
`define MECR_PIN_WR   2
`define MECR_PIN_ABRT 3
`define MECR_PIN_DIAG 4
`define MECR_PIN_C2S  10
`define MECR_PIN_SBYD 12
`define MECR_PIN_MSTD 13
`endif

/* mecr_pkg.sv */
// Purpose: types of the master error code reporter
// Assumes: constants come from the cfg header
// Notes:   none
`include "mecr_cfg.svh"
package mecr_pkg;
   typedef logic [17:0] mecr_evt_t;   // one bit per error code
   typedef enum logic {MECR_IDLE = 1'b0, MECR_WIN = 1'b1} mecr_cons_e;
   // synchroniser stages
   typedef struct packed
   {
      logic [`MECR_PIN_W-1:0] s1;
      logic [`MECR_PIN_W-1:0] s2;
   } mecr_sync_s;
   // state of the reporter
   typedef struct packed
   {
      mecr_evt_t              status;
      mecr_evt_t              mask;
      logic [15:0]            code;
      logic                   err_act;
      logic                   auto_cons;
      logic                   clr_active;
      mecr_cons_e             cons;
      logic                   rd_seen;
      logic                   wr_seen;
      logic [6:0]             sby_addr;
      logic [6:0]             ctl_addr;
      logic [`MECR_PIN_W-1:0] pin_prev;
      logic [1:0]             cond_prev;
      logic [31:0]            prdata;
      logic                   pslverr;
   } mecr_state_s;
endpackage

/* mecr_sync.sv */
// Purpose: two-stage synchroniser for the pin inputs
// Assumes: pins are asynchronous to CLK
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module mecr_sync
   import mecr_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [`MECR_PIN_W-1:0] din,
   output logic      [`MECR_PIN_W-1:0] dout
);
   mecr_sync_s q;       // registered stages
   mecr_sync_s next_q;  // next stages

   // shift the pins through two stages
   always_comb
   begin
      next_q    = q;
      next_q.s1 = din;
      next_q.s2 = q.s1;
   end

   // register the stages
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= next_q;
   end

   assign dout = q.s2;
endmodule
`default_nettype wire

/* mecr_code_sel.sv */
// Purpose: pick the error code of a set of new events
// Assumes: events are one-cycle pulses
// Notes:   lowest event bit wins when several coincide
`timescale 1ns/1ps
`default_nettype none
module mecr_code_sel
   import mecr_pkg::*;
(
   input  wire mecr_evt_t evt,
   output logic [15:0]    code
);
   // code for each event bit
   localparam logic [15:0] TBL [0:17] = '{
      16'hF110, 16'hF111, 16'hF112, 16'hF113, 16'hF114, 16'hF120,
      16'hF121, 16'hF122, 16'hF123, 16'hF124, 16'hF125, 16'hF126,
      16'hFB00, 16'hFB01, 16'hFB02, 16'hFB03, 16'hFB04, 16'hF100};
   logic [15:0] chain [0:18];  // priority chain, high end empty

   assign chain[18] = 16'h0000;
   // one priority stage per event bit
   for (genvar i = 0; i < 18; i++)
   begin : g_sel
      assign chain[i] = evt[i] ? TBL[i] : chain[i+1];
   end
   assign code = chain[0];
endmodule
`default_nettype wire

/* mecr_top.sv */
// Purpose: error detection and code reporting of a fieldbus master
// Assumes: APB slave, 250 MHz CLK, pins asynchronous
// Notes:
// Functional notes
// R01 - unexecuted block read/write gives F110/F111/F112
// R02 - host runs block instructions only under request
// R03 - request during automatic consistency gives F113
// R04 - no instruction window while automatic consistency; the code keeps an already open window open when auto_cons is set
// R05 - aborted mode change gives F114, fault lit
// R06 - slave diagnostics give F120, response error lit
// R07 - duplicate station on line gives F121
// R08 - line or parameter errors give F122..F124
// R09 - clear request state gives F125
// R10 - clear request sent only if action enabled
// R11 - line or hardware error gives F126
// R12 - standby address out of range gives FB00
// R13 - control equals standby address gives FB01
// R14 - standby equals slave address gives FB02
// R15 - control to standby switch failure gives FB03
// R16 - standby to control switch failure gives FB04
// R17 - last code held until replaced or cleared
// R18 - slave duplicates master address gives F100
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mecr_top
   import mecr_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        CONSISTENCY_START_REQUEST,
   input  wire logic        CONSISTENT_BLOCK_READ_INSTR,
   input  wire logic        CONSISTENT_BLOCK_WRITE_INSTR,
   input  wire logic        MODE_CHANGE_ABORT,
   input  wire logic        SLAVE_DIAG,
   input  wire logic        DUP_STATION_ON_LINE,
   input  wire logic        LINE_ERROR,
   input  wire logic        SLAVE_INTERVAL_ERROR,
   input  wire logic        MASTER_PARAM_ERROR,
   input  wire logic        LINE_OR_HW_ERROR,
   input  wire logic        CTL_TO_SBY_FAIL,
   input  wire logic        SBY_TO_CTL_FAIL,
   input  wire logic        SBY_SLAVE_ADDR_DUP,
   input  wire logic        MASTER_SLAVE_ADDR_DUP,
   output logic             FAULT_INDICATOR,
   output logic             RESPONSE_ERROR_INDICATOR,
   output logic             CLEAR_REQUEST_TX,
   output logic             CONSISTENCY_ACTIVE,
   output logic      [15:0] ERROR_CODE,
   output logic             IRQ
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   mecr_state_s            q;        // registered state
   mecr_state_s            next_q;   // next state
   logic [`MECR_PIN_W-1:0] pin;      // synchronised pins
   logic [`MECR_PIN_W-1:0] rise;     // pin rising edges
   logic [1:0]             cond;     // address checks
   mecr_evt_t              ev;       // new events this cycle
   logic [15:0]            sel_code; // code of the new events
   logic                   req_fall; // window closes
   logic                   rd_now;   // read seen incl. this cycle
   logic                   wr_now;   // write seen incl. this cycle
   logic                   wr_acc;   // write access phase
   logic                   setup;    // setup phase

   // ----------------------------------------
   // pin synchroniser and code selector
   // ----------------------------------------
   mecr_sync u_sync
   (
      .clk   (CLK),
      .rst_n (RST_N),
      .din   ({MASTER_SLAVE_ADDR_DUP, SBY_SLAVE_ADDR_DUP,
               SBY_TO_CTL_FAIL, CTL_TO_SBY_FAIL, LINE_OR_HW_ERROR,
               MASTER_PARAM_ERROR, SLAVE_INTERVAL_ERROR, LINE_ERROR,
               DUP_STATION_ON_LINE, SLAVE_DIAG, MODE_CHANGE_ABORT,
               CONSISTENT_BLOCK_WRITE_INSTR,
               CONSISTENT_BLOCK_READ_INSTR,
               CONSISTENCY_START_REQUEST}),
      .dout  (pin)
   );

   mecr_code_sel u_sel
   (
      .evt  (ev),
      .code (sel_code)
   );

   // ----------------------------------------
   // helper terms
   // ----------------------------------------
   assign rise     = pin & ~q.pin_prev;
   assign cond[0]  = q.sby_addr > `MECR_ADDR_MAX;  // R12
   assign cond[1]  = q.ctl_addr == q.sby_addr;     // R13
   assign req_fall = (q.cons == MECR_WIN) & ~pin[`MECR_PIN_REQ];
   assign rd_now   = q.rd_seen | pin[`MECR_PIN_RD];
   assign wr_now   = q.wr_seen | pin[`MECR_PIN_WR];
   assign wr_acc   = PSEL & PENABLE & PWRITE;
   assign setup    = PSEL & ~PENABLE;

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   always_comb
   begin
      ev = '0;
      // end of consistency window with missing instructions
      ev[`MECR_EV_F110] = req_fall & ~rd_now & wr_now;   // R01
      ev[`MECR_EV_F111] = req_fall & rd_now & ~wr_now;   // R01
      ev[`MECR_EV_F112] = req_fall & ~rd_now & ~wr_now;  // R01
      // request while automatic consistency runs
      ev[`MECR_EV_F113] = rise[`MECR_PIN_REQ] & q.auto_cons;  // R03
      ev[`MECR_EV_F114] = rise[`MECR_PIN_ABRT];          // R05
      ev[`MECR_EV_F120] = rise[`MECR_PIN_DIAG];          // R06
      // F121 to F124 follow the pin order
      ev[9:6]           = rise[8:5];                     // R07 R08
      ev[11]            = rise[9];                       // R11
      ev[`MECR_EV_FB00] = cond[0] & ~q.cond_prev[0];     // R12
      ev[`MECR_EV_FB01] = cond[1] & ~q.cond_prev[1];     // R13
      // FB03 and FB04 follow the pin order, FB02 comes from pin 12
      ev[16:14]         = {rise[11:10], rise[`MECR_PIN_SBYD]};  // R14 R15 R16
      ev[`MECR_EV_F100] = rise[`MECR_PIN_MSTD];          // R18
      // response error while action is enabled enters clear state
      if (q.err_act & ~q.clr_active & (|(ev & `MECR_RSP_GRP)))
      begin
         ev[`MECR_EV_F125] = 1'b1;                       // R09
      end
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic        leave;  // leave clear state pulse
      logic        cclr;   // clear error code pulse
      mecr_evt_t   w1c;    // status bits to clear
      leave       = 1'b0;
      cclr        = 1'b0;
      w1c         = '0;
      next_q      = q;
      next_q.pin_prev  = pin;
      next_q.cond_prev = cond;
      // consistency window
      case (q.cons)
         MECR_IDLE:
         begin
            // the instruction window never opens under auto refresh
            if (rise[`MECR_PIN_REQ] & ~q.auto_cons)  // R04
            begin
               next_q.cons    = MECR_WIN;
               next_q.rd_seen = 1'b0;
               next_q.wr_seen = 1'b0;
            end
         end
         MECR_WIN:
         begin
            // host runs block instructions here
            next_q.rd_seen = rd_now;  // R02
            next_q.wr_seen = wr_now;
            if (req_fall)
               next_q.cons = MECR_IDLE;
         end
         default:
            next_q.cons = MECR_IDLE;
      endcase
      // register writes take effect in the access phase
      if (wr_acc)
      begin
         case (PADDR)
            `MECR_OFF_STATUS:
               w1c = PWDATA[17:0];
            `MECR_OFF_MASK:
               next_q.mask = PWDATA[17:0];
            `MECR_OFF_CTRL:
            begin
               next_q.err_act   = PWDATA[`MECR_CTRL_ERRACT];
               next_q.auto_cons = PWDATA[`MECR_CTRL_AUTO];
               leave            = PWDATA[`MECR_CTRL_LEAVE];
               cclr             = PWDATA[`MECR_CTRL_CCLR];
            end
            `MECR_OFF_ADDR:
            begin
               next_q.sby_addr = PWDATA[6:0];
               next_q.ctl_addr = PWDATA[14:8];
            end
            default:
               w1c = '0;
         endcase
      end
      // sticky status, a new event wins over its clear
      next_q.status = (q.status & ~w1c) | ev;
      // last code held until replaced or cleared
      if (|ev)
         next_q.code = sel_code;  // R17
      else if (cclr)
         next_q.code = 16'h0000;  // R17
      // clear request transmission state
      if (leave | ~q.err_act)
         next_q.clr_active = 1'b0;  // R10
      if (ev[`MECR_EV_F125])
         next_q.clr_active = 1'b1;  // R09
      // read data captured in the setup phase
      next_q.pslverr = 1'b0;
      if (setup)
      begin
         case (PADDR)
            `MECR_OFF_STATUS:
               next_q.prdata = {14'h0000, q.status};
            `MECR_OFF_MASK:
               next_q.prdata = {14'h0000, q.mask};
            `MECR_OFF_CODE:
               next_q.prdata = {16'h0000, q.code};
            `MECR_OFF_CTRL:
               next_q.prdata = {26'h0000000, q.cons == MECR_WIN,
                                q.clr_active, 2'b00, q.auto_cons,
                                q.err_act};
            `MECR_OFF_ADDR:
               next_q.prdata = {17'h00000, q.ctl_addr, 1'b0,
                                q.sby_addr};
            default:
            begin
               next_q.prdata  = 32'h00000000;
               next_q.pslverr = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         q          <= '0;
         q.mask     <= `MECR_RST_MASK;
         q.sby_addr <= `MECR_RST_SBY;
         q.ctl_addr <= `MECR_RST_CTL;
      end
      else
         q <= next_q;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign PRDATA  = q.prdata;
   assign PREADY  = PSEL & PENABLE;
   assign PSLVERR = PSEL & PENABLE & q.pslverr;
   assign FAULT_INDICATOR          = |(q.status & `MECR_FAULT_GRP);
   assign RESPONSE_ERROR_INDICATOR = |(q.status & `MECR_RSP_GRP);
   assign CLEAR_REQUEST_TX   = q.clr_active;  // R10
   assign CONSISTENCY_ACTIVE = q.cons == MECR_WIN;
   assign ERROR_CODE = q.code;
   assign IRQ        = |(q.status & q.mask);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_win_empty;
      q.cons == MECR_WIN ##1 req_fall && !rd_now && !wr_now;
   endsequence

   chk_window_empty: assert property (s_win_empty |=> // R01
      q.status[`MECR_EV_F112] && ERROR_CODE == 16'hF112)
      else $error("empty window did not give F112");
   chk_auto_conflict: assert property ( // R03
      $rose(pin[`MECR_PIN_REQ]) && q.auto_cons && q.cons == MECR_IDLE
      |=> q.status[`MECR_EV_F113] && !CONSISTENCY_ACTIVE)
      else $error("request under auto refresh not flagged");
   chk_no_window: assert property ( // R04
      q.auto_cons && q.cons == MECR_IDLE |=> !CONSISTENCY_ACTIVE)
      else $error("window opened under auto refresh");
   chk_abort_fault: assert property ( // R05
      ev[`MECR_EV_F114] |=> FAULT_INDICATOR ##0 ERROR_CODE == 16'hF114)
      else $error("mode abort not reported");
   chk_diag_rsp: assert property ( // R06
      ev[`MECR_EV_F120] |=> RESPONSE_ERROR_INDICATOR)
      else $error("slave diagnostics not reported");
   chk_clear_code: assert property ( // R09
      $rose(CLEAR_REQUEST_TX) |-> q.status[`MECR_EV_F125])
      else $error("clear state without F125");
   chk_clear_off: assert property ( // R10
      !q.err_act |=> !CLEAR_REQUEST_TX)
      else $error("clear request with action disabled");
   chk_addr_dup: assert property ( // R13
      $rose(cond[1]) |=> ##1 FAULT_INDICATOR)
      else $error("address duplicate not reported");
   chk_code_held: assert property ( // R17
      ev == '0 && !(wr_acc && PADDR == `MECR_OFF_CTRL)
      |=> $stable(ERROR_CODE))
      else $error("error code changed without cause");

   // write seen but read missing
   sequence s_win_write_only;
      q.cons == MECR_WIN ##1 req_fall && !rd_now && wr_now;
   endsequence
   // read seen but write missing
   sequence s_win_read_only;
      q.cons == MECR_WIN ##1 req_fall && rd_now && !wr_now;
   endsequence

   chk_missing_read: assert property (s_win_write_only |=> // R01
      q.status[`MECR_EV_F110] && ERROR_CODE == 16'hF110)
      else $error("write-only window did not give F110");
   chk_missing_write: assert property (s_win_read_only |=> // R01
      q.status[`MECR_EV_F111] && ERROR_CODE == 16'hF111)
      else $error("read-only window did not give F111");
   // line events light the response indicator
   chk_dup_station: assert property ( // R07
      ev[6] && ev[5:0] == '0
      |=> RESPONSE_ERROR_INDICATOR && ERROR_CODE == 16'hF121)
      else $error("duplicate station not reported");
   chk_line_or_hw: assert property ( // R11
      ev[11] |=> RESPONSE_ERROR_INDICATOR && q.status[11])
      else $error("line or hardware error not reported");
   // address and switching faults light the fault indicator
   chk_sby_range: assert property ( // R12
      $rose(cond[0]) |=> FAULT_INDICATOR && q.status[`MECR_EV_FB00])
      else $error("standby range error not reported");
   chk_sby_slave: assert property ( // R14
      rise[`MECR_PIN_SBYD] |=> FAULT_INDICATOR && q.status[14])
      else $error("standby slave clash not reported");
   chk_switch_fail: assert property ( // R15 R16
      |rise[11:10] |=> FAULT_INDICATOR && |q.status[16:15])
      else $error("role switch failure not reported");
   chk_master_dup: assert property ( // R18
      rise[`MECR_PIN_MSTD] |=> FAULT_INDICATOR && q.status[17])
      else $error("master address clash not reported");
   // software clear of the held code
   chk_code_clear: assert property ( // R17
      ev == '0 && wr_acc && PADDR == `MECR_OFF_CTRL
      && PWDATA[`MECR_CTRL_CCLR] |=> ERROR_CODE == 16'h0000)
      else $error("error code not cleared");
endmodule
`default_nettype wire

/* mecr_host_model.sv */
// Purpose: host and bus side model that drives the event pins
// Assumes: the block synchronises every pin before use
// Notes:   pin index equals the status bit of its event,
//          pin 0 request, pin 1 block read, pin 2 block write
`timescale 1ns/1ps
`default_nettype none
module mecr_host_model
   import mecr_pkg::*;
(
   input  wire logic        clk,
   output var  logic [17:0] pin
);
   // ----------------------------------------
   // pin driving
   // ----------------------------------------
   // every line idles low until a scenario moves it
   initial pin = '0;

   // move one line just after a clock edge
   task automatic set_pin(input int idx, input logic val);
      @(posedge clk);
      pin[idx] <= val;
   endtask

   // block instructions, issued only while the request is held
   task automatic run_instr(input logic rd, input logic wr);
      @(posedge clk);
      pin[1] <= rd;
      pin[2] <= wr;
      repeat (3) @(posedge clk);
      pin[2:1] <= 2'b00;
   endtask
endmodule
`default_nettype wire

/* mecr_top_tb.sv */
// Purpose: self-checking bench of the error code reporter
// Assumes: zero wait APB slave, pins seen three edges after a rise
// Notes:   one task per scenario, each judges its own results
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      num_checks++; \
      if ((got) !== (ex)) \
      begin \
         bad_count++; \
         $display("[FAIL] %s exp %h got %h", nm, ex, got); \
      end \
   end
module mecr_top_tb;
   import mecr_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clk, rst_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, rerr;
   logic        fault, rsp, clr, act, irq;
   logic [15:0] code;
   logic [17:0] pin;
   int          bad_count, num_checks, cyc;

   // 250 MHz clock
   always #2 clk = ~clk;

   mecr_top i_mecr_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CONSISTENCY_START_REQUEST(pin[0]),
      .CONSISTENT_BLOCK_READ_INSTR(pin[1]),
      .CONSISTENT_BLOCK_WRITE_INSTR(pin[2]),
      .MODE_CHANGE_ABORT(pin[4]), .SLAVE_DIAG(pin[5]),
      .DUP_STATION_ON_LINE(pin[6]), .LINE_ERROR(pin[7]),
      .SLAVE_INTERVAL_ERROR(pin[8]), .MASTER_PARAM_ERROR(pin[9]),
      .LINE_OR_HW_ERROR(pin[11]), .CTL_TO_SBY_FAIL(pin[15]),
      .SBY_TO_CTL_FAIL(pin[16]), .SBY_SLAVE_ADDR_DUP(pin[14]),
      .MASTER_SLAVE_ADDR_DUP(pin[17]), .FAULT_INDICATOR(fault),
      .RESPONSE_ERROR_INDICATOR(rsp), .CLEAR_REQUEST_TX(clr),
      .CONSISTENCY_ACTIVE(act), .ERROR_CODE(code), .IRQ(irq));

   mecr_host_model i_mecr_host_model (.clk(clk), .pin(pin));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   // one APB transfer, read data and error kept in rdat and rerr
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready high ends this wait; without it only the bench timeout does
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // let n edges pass, then sample settled outputs
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // code that a given status bit stands for
   function automatic logic [15:0] exp_code(input int b);
      if (b < 5)
         return 16'(16'hF110 + b);
      if (b < 12)
         return 16'(16'hF120 + b - 5);
      if (b < 17)
         return 16'(16'hFB00 + b - 12);
      return 16'hF100;
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // reset values and an unmapped address
   task automatic t_reset;
      apb(1'b0, `MECR_OFF_MASK, 32'h0);
      `CHK("mask", 32'h0003FFFF, rdat)
      `CHK("mask slverr", 1'b0, rerr)
      apb(1'b0, `MECR_OFF_ADDR, 32'h0);
      `CHK("addr", 32'h00000201, rdat)
      apb(1'b0, `MECR_OFF_CODE, 32'h0);
      `CHK("code reg", 32'h0, rdat)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("slverr", 1'b1, rerr)
      $display("test reset done");
   endtask

   // every event pin: code, indicator group, irq, no clear request
   task automatic t_events;
      int evb [11] = '{4, 5, 6, 7, 8, 9, 11, 14, 15, 16, 17};
      int b;
      foreach (evb[i])
      begin
         b = evb[i];
         i_mecr_host_model.set_pin(b, 1'b1);
         settle(5);
         `CHK("code", exp_code(b), code)
         `CHK("fault", (b == 4 || b >= 12), fault)
         `CHK("rsp", (b >= 5 && b <= 11), rsp)
         `CHK("irq", 1'b1, irq)
         `CHK("clr tx", 1'b0, clr)
         apb(1'b0, `MECR_OFF_STATUS, 32'h0);
         `CHK("status", 32'(1 << b), rdat)
         i_mecr_host_model.set_pin(b, 1'b0);
         apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
         settle(1);
         `CHK("irq off", 1'b0, irq)
      end
      $display("test events done");
   endtask

   // window with each mix of block read and write
   task automatic t_consist;
      logic [15:0] ec [4] = '{16'hF112, 16'hF111, 16'hF110, 16'h0};
      logic [31:0] es [4] = '{32'h4, 32'h2, 32'h1, 32'h0};
      apb(1'b1, `MECR_OFF_CTRL, 32'h8);
      for (int k = 3; k >= 0; k--)
      begin
         i_mecr_host_model.set_pin(0, 1'b1);
         settle(5);
         `CHK("window", 1'b1, act)
         apb(1'b0, `MECR_OFF_CTRL, 32'h0);
         `CHK("ctrl win", 32'h20, rdat)
         i_mecr_host_model.run_instr(k[0], k[1]);
         i_mecr_host_model.set_pin(0, 1'b0);
         settle(5);
         `CHK("window shut", 1'b0, act)
         `CHK("cons code", ec[k], code)
         apb(1'b0, `MECR_OFF_STATUS, 32'h0);
         `CHK("cons status", es[k], rdat)
         apb(1'b1, `MECR_OFF_STATUS, 32'h7);
      end
      $display("test consistency done");
   endtask

   // request while automatic consistency runs
   task automatic t_auto;
      apb(1'b1, `MECR_OFF_CTRL, 32'h2);
      i_mecr_host_model.set_pin(0, 1'b1);
      settle(5);
      `CHK("no window", 1'b0, act)
      `CHK("auto code", 16'hF113, code)
      i_mecr_host_model.set_pin(0, 1'b0);
      apb(1'b1, `MECR_OFF_CTRL, 32'h0);
      apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
      $display("test auto done");
   endtask

   // clear request with error action on, then leave it
   task automatic t_clear;
      apb(1'b1, `MECR_OFF_CTRL, 32'h1);
      i_mecr_host_model.set_pin(5, 1'b1);
      settle(5);
      `CHK("clr tx on", 1'b1, clr)
      apb(1'b0, `MECR_OFF_CTRL, 32'h0);
      `CHK("ctrl clr", 32'h11, rdat)
      apb(1'b0, `MECR_OFF_STATUS, 32'h0);
      `CHK("clr status", 32'h420, rdat)
      `CHK("clr code", 16'hF120, code)
      apb(1'b1, `MECR_OFF_CTRL, 32'h5);
      settle(2);
      `CHK("clr tx off", 1'b0, clr)
      i_mecr_host_model.set_pin(5, 1'b0);
      apb(1'b1, `MECR_OFF_CTRL, 32'h0);
      apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
      $display("test clear done");
   endtask

   // standby address at the limit, past it, and equal to control
   task automatic t_addr;
      apb(1'b1, `MECR_OFF_ADDR, 32'h027D);
      settle(3);
      `CHK("addr ok", 1'b0, fault)
      apb(1'b1, `MECR_OFF_ADDR, 32'h027E);
      settle(3);
      `CHK("range code", 16'hFB00, code)
      `CHK("range fault", 1'b1, fault)
      apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
      apb(1'b1, `MECR_OFF_ADDR, 32'h0202);
      settle(3);
      `CHK("dup code", 16'hFB01, code)
      `CHK("dup fault", 1'b1, fault)
      apb(1'b1, `MECR_OFF_ADDR, 32'h0201);
      apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
      $display("test address done");
   endtask

   // masked interrupt, then code cleared by software
   task automatic t_mask;
      apb(1'b1, `MECR_OFF_MASK, 32'h0);
      i_mecr_host_model.set_pin(9, 1'b1);
      settle(5);
      `CHK("masked irq", 1'b0, irq)
      `CHK("held code", 16'hF124, code)
      apb(1'b1, `MECR_OFF_MASK, 32'h200);
      settle(1);
      `CHK("unmasked irq", 1'b1, irq)
      apb(1'b1, `MECR_OFF_CTRL, 32'h8);
      settle(1);
      `CHK("code cleared", 16'h0, code)
      i_mecr_host_model.set_pin(9, 1'b0);
      apb(1'b1, `MECR_OFF_STATUS, 32'h0003FFFF);
      $display("test mask done");
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   // hang guard well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         tally_and_finish;
      end
   end

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_events;
      t_consist;
      t_auto;
      t_clear;
      t_addr;
      t_mask;
      tally_and_finish;
   end
endmodule
`default_nettype wire
